// file: mcp_defs.svh
`ifndef MCP_DEFS_SVH
`define MCP_DEFS_SVH
// What this block does
// - Default start: regulator first, then the reference
// - Then oscillator, 3.3 V, 5 V, boost in order
// - Command after regulator sets each converter independently
// - All converters off stops the oscillator
// - Per-converter soft-start ramps peak limit over 4 ms
// - Soft-start starts on default sequence or command
// - Tie 5 V output to regulator above 4.5 V
// - High gate on dead time after clock edge
// - Low gate after dead time until edge or zero
// - Skipped clock cycle means pulse-skip, else normal
// - Pulse-skip high gate ends at 20 mV or duty
// - Pulse-skip low gate holds until zero current
// - Idle while above regulation, pulse at next edge
// - Above 120 mV limit, high gate off immediately
// - Current limit ends only the present cycle
// - Boost gates switch together in phase
// - Normal boost: on at edge, off after on-time
// - Pulse-skip boost ends at 100 mV or duty
// - Boost idles until output falls below regulation
// - Boost above 410 mV limit turns both off
// - Command bits 7..5 enable 3.3 V, 5 V, boost
// - Aborted transfer leaves enables unchanged
// - Disabled section holds both gates off

// ****************************************
// Timing
// ****************************************
`define MCP_CLK_NS 5
`define MCP_DEAD_TIME_NS 40
`define MCP_DEAD_CYC ((`MCP_DEAD_TIME_NS + `MCP_CLK_NS - 1) / `MCP_CLK_NS)
`define MCP_SW_PERIOD_NS 5000
`define MCP_SW_CYC (`MCP_SW_PERIOD_NS / `MCP_CLK_NS)
`define MCP_MAX_DUTY_CYC 900
`define MCP_SS_TIME_MS 4
`define MCP_SS_CYC (`MCP_SS_TIME_MS * 1000000 / `MCP_CLK_NS)
`define MCP_SS_STEPS 256

// ****************************************
// Command byte fields
// ****************************************
`define MCP_EN_3V3_BIT 7
`define MCP_EN_5V_BIT 6
`define MCP_EN_BOOST_BIT 5
`endif

// file: mcp_pkg.sv
package mcp_pkg;
    typedef enum logic [2:0] {
        MCP_BK_IDLE, MCP_BK_DEAD_HI, MCP_BK_HIGH, MCP_BK_DEAD_LO, MCP_BK_LOW
    } mcp_buck_t;
    typedef enum logic [2:0] {
        MCP_SQ_LDO, MCP_SQ_REF, MCP_SQ_3V3, MCP_SQ_5V, MCP_SQ_BOOST, MCP_SQ_RUN
    } mcp_seq_t;
endpackage

// file: mcp_sequencer.sv
`timescale 1ns/10ps
`default_nettype none
`include "mcp_defs.svh"
module mcp_sequencer #(
    parameter int SOFT_START_CYCLES = `MCP_SS_CYC
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Analog supervisors (asynchronous)
    input wire logic ldo_ok,
    input wire logic ref_ok,
    input wire logic out5_above_4v5,
    // 3.3 V buck comparators (asynchronous)
    input wire logic ontime_done_3v3,
    input wire logic peak_trip_3v3,
    input wire logic ilim_trip_3v3,
    input wire logic zero_cur_3v3,
    input wire logic below_reg_3v3,
    // 5 V buck comparators (asynchronous)
    input wire logic ontime_done_5v,
    input wire logic peak_trip_5v,
    input wire logic ilim_trip_5v,
    input wire logic zero_cur_5v,
    input wire logic below_reg_5v,
    // Boost comparators (asynchronous)
    input wire logic ontime_done_boost,
    input wire logic peak_trip_boost,
    input wire logic ilim_trip_boost,
    input wire logic below_reg_boost,
    // Command decoder (same clock)
    input wire logic cmd_valid,
    input wire logic [7:0] cmd_byte,
    input wire logic cmd_abort,
    // Supply control
    output logic ldo_en,
    output logic ref_en,
    output logic osc_run,
    output logic ldo_tie_close,
    // Soft-start peak limit levels
    output logic [7:0] ss_level_3v3,
    output logic [7:0] ss_level_5v,
    output logic [7:0] ss_level_boost,
    // Mode flags
    output logic pulse_skip_state_3v3,
    output logic pulse_skip_state_5v,
    output logic pulse_skip_state_boost,
    // Gate drives
    output logic high_gate_3v3,
    output logic low_gate_3v3,
    output logic high_gate_5v,
    output logic low_gate_5v,
    output logic high_gate_boost,
    output logic low_gate_boost
);
    localparam int SS_STEP = SOFT_START_CYCLES / `MCP_SS_STEPS;

    // ****************************************
    // Input synchronisers
    // ****************************************
    logic [16:0] sync1, sync2;
    logic [2:0] s_ontime, s_peak, s_ilim, s_below;
    logic [1:0] s_zero;
    logic s_ldo, s_ref, s_out5;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            sync1 <= 17'h0;
            sync2 <= 17'h0;
        end else begin
            sync1 <= {ontime_done_boost, ontime_done_5v, ontime_done_3v3,
                      peak_trip_boost, peak_trip_5v, peak_trip_3v3,
                      ilim_trip_boost, ilim_trip_5v, ilim_trip_3v3,
                      zero_cur_5v, zero_cur_3v3,
                      below_reg_boost, below_reg_5v, below_reg_3v3,
                      ldo_ok, ref_ok, out5_above_4v5};
            sync2 <= sync1;
        end
    end

    assign {s_ontime, s_peak, s_ilim, s_zero, s_below, s_ldo, s_ref, s_out5} = sync2;

    // ****************************************
    // Power-up sequencer and command handling
    // ****************************************
    mcp_pkg::mcp_seq_t seq, next_seq;
    logic [2:0] en, next_en;
    logic [2:0] ss_done;

    always_comb begin
        next_seq = seq;
        next_en = en;
        unique case (seq)
            mcp_pkg::MCP_SQ_LDO: if (s_ldo) next_seq = mcp_pkg::MCP_SQ_REF;
            mcp_pkg::MCP_SQ_REF: if (s_ref) begin
                next_seq = mcp_pkg::MCP_SQ_3V3;
                next_en[0] = 1'b1;
            end
            mcp_pkg::MCP_SQ_3V3: if (ss_done[0]) begin
                next_seq = mcp_pkg::MCP_SQ_5V;
                next_en[1] = 1'b1;
            end
            mcp_pkg::MCP_SQ_5V: if (ss_done[1]) begin
                next_seq = mcp_pkg::MCP_SQ_BOOST;
                next_en[2] = 1'b1;
            end
            mcp_pkg::MCP_SQ_BOOST: if (ss_done[2]) next_seq = mcp_pkg::MCP_SQ_RUN;
            mcp_pkg::MCP_SQ_RUN: next_seq = seq;
        endcase
        // Only a completed transfer takes effect; a byte flagged cmd_abort is dropped
        if (cmd_valid && !cmd_abort && seq != mcp_pkg::MCP_SQ_LDO) begin
            next_seq = mcp_pkg::MCP_SQ_RUN;
            next_en = {cmd_byte[`MCP_EN_BOOST_BIT], cmd_byte[`MCP_EN_5V_BIT],
                       cmd_byte[`MCP_EN_3V3_BIT]};
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            seq <= mcp_pkg::MCP_SQ_LDO;
            en <= 3'h0;
        end else begin
            seq <= next_seq;
            en <= next_en;
        end
    end

    assign ldo_en = 1'b1;
    assign ref_en = (seq != mcp_pkg::MCP_SQ_LDO);

    // ****************************************
    // Oscillator: gated switching clock tick
    // ****************************************
    logic [9:0] osc_cnt, next_osc_cnt;
    logic osc_q, next_osc_q, tick, tie_q;

    always_comb begin
        next_osc_q = |en;
        next_osc_cnt = 10'h0;
        if (osc_q && osc_cnt != 10'(`MCP_SW_CYC - 1)) next_osc_cnt = osc_cnt + 10'h1;
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            osc_q <= 1'b0;
            osc_cnt <= 10'h0;
            tie_q <= 1'b0;
        end else begin
            osc_q <= next_osc_q;
            osc_cnt <= next_osc_cnt;
            tie_q <= s_out5;
        end
    end

    assign osc_run = osc_q;
    assign tick = osc_q && (osc_cnt == 10'(`MCP_SW_CYC - 1));
    assign ldo_tie_close = tie_q;

    // ****************************************
    // Soft-start ramps and mode flags
    // ****************************************
    // One element per converter, so each generate branch owns its own flop
    logic en_q [3];
    logic pskip [3];
    logic [7:0] ss_lvl [3];

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_ss
            logic [11:0] div, next_div;
            logic [7:0] next_lvl;
            logic next_pskip;

            always_comb begin
                next_div = div;
                next_lvl = ss_lvl[gi];
                next_pskip = pskip[gi];
                if (!en[gi] || !en_q[gi]) begin
                    next_div = 12'h0;
                    next_lvl = 8'h0;
                end else if (ss_lvl[gi] != 8'hff) begin
                    if (div == 12'(SS_STEP - 1)) begin
                        next_div = 12'h0;
                        next_lvl = ss_lvl[gi] + 8'h1;
                    end else begin
                        next_div = div + 12'h1;
                    end
                end
                if (tick && en[gi]) next_pskip = !s_below[gi];
            end

            always_ff @(posedge clk_sys) begin
                if (rst) begin
                    div <= 12'h0;
                    ss_lvl[gi] <= 8'h0;
                    en_q[gi] <= 1'b0;
                    pskip[gi] <= 1'b0;
                end else begin
                    div <= next_div;
                    ss_lvl[gi] <= next_lvl;
                    en_q[gi] <= en[gi];
                    pskip[gi] <= next_pskip;
                end
            end

            assign ss_done[gi] = (ss_lvl[gi] == 8'hff);
        end
    endgenerate

    assign ss_level_3v3 = ss_lvl[0];
    assign ss_level_5v = ss_lvl[1];
    assign ss_level_boost = ss_lvl[2];
    assign pulse_skip_state_3v3 = pskip[0];
    assign pulse_skip_state_5v = pskip[1];
    assign pulse_skip_state_boost = pskip[2];

    // ****************************************
    // Buck gate-drive state machines
    // ****************************************
    mcp_pkg::mcp_buck_t bst [2];
    logic [9:0] bcnt [2];
    logic [1:0] hg, lg;

    generate
        for (gi = 0; gi < 2; gi++) begin : g_buck
            mcp_pkg::mcp_buck_t next_st;
            logic [9:0] next_cnt;
            logic hi_end;

            always_comb begin
                next_st = bst[gi];
                next_cnt = bcnt[gi] + 10'h1;
                hi_end = s_ilim[gi] || bcnt[gi] == 10'(`MCP_MAX_DUTY_CYC - 1)
                         || (pskip[gi] ? s_peak[gi] : s_ontime[gi]);
                unique case (bst[gi])
                    mcp_pkg::MCP_BK_IDLE: begin
                        next_cnt = 10'h0;
                        if (tick && en[gi] && s_below[gi]) next_st = mcp_pkg::MCP_BK_DEAD_HI;
                    end
                    mcp_pkg::MCP_BK_DEAD_HI:
                        if (bcnt[gi] == 10'(`MCP_DEAD_CYC - 1)) begin
                            next_st = mcp_pkg::MCP_BK_HIGH;
                            next_cnt = 10'h0;
                        end
                    mcp_pkg::MCP_BK_HIGH:
                        if (hi_end) begin
                            next_st = mcp_pkg::MCP_BK_DEAD_LO;
                            next_cnt = 10'h0;
                        end
                    mcp_pkg::MCP_BK_DEAD_LO:
                        if (bcnt[gi] == 10'(`MCP_DEAD_CYC - 1)) begin
                            next_st = mcp_pkg::MCP_BK_LOW;
                            next_cnt = 10'h0;
                        end
                    mcp_pkg::MCP_BK_LOW: begin
                        next_cnt = 10'h0;
                        if (s_zero[gi]) begin
                            next_st = mcp_pkg::MCP_BK_IDLE;
                        end else if (tick && !pskip[gi]) begin
                            next_st = s_below[gi] ? mcp_pkg::MCP_BK_DEAD_HI
                                                  : mcp_pkg::MCP_BK_IDLE;
                        end
                    end
                endcase
                if (!en[gi]) begin
                    next_st = mcp_pkg::MCP_BK_IDLE;
                    next_cnt = 10'h0;
                end
            end

            always_ff @(posedge clk_sys) begin
                if (rst) begin
                    bst[gi] <= mcp_pkg::MCP_BK_IDLE;
                    bcnt[gi] <= 10'h0;
                end else begin
                    bst[gi] <= next_st;
                    bcnt[gi] <= next_cnt;
                end
            end

            // Limit trip masks the drive at once rather than a cycle later
            assign hg[gi] = (bst[gi] == mcp_pkg::MCP_BK_HIGH) && !s_ilim[gi];
            assign lg[gi] = (bst[gi] == mcp_pkg::MCP_BK_LOW);

            sequence dead_gap_s;
                !lg[gi] [*8];
            endsequence

            no_overlap_a: assert property (@(posedge clk_sys) disable iff (rst)
                !(hg[gi] && lg[gi])) else $error("buck gates overlap");
            dead_gap_a: assert property (@(posedge clk_sys) disable iff (rst)
                $fell(bst[gi] == mcp_pkg::MCP_BK_HIGH) |-> dead_gap_s)
                else $error("low gate before dead time");
            ilim_cut_a: assert property (@(posedge clk_sys) disable iff (rst)
                s_ilim[gi] |-> !hg[gi]) else $error("high gate on at limit");
            duty_cap_a: assert property (@(posedge clk_sys) disable iff (rst)
                bst[gi] == mcp_pkg::MCP_BK_HIGH |-> bcnt[gi] < 10'(`MCP_MAX_DUTY_CYC))
                else $error("duty exceeds maximum");
            buck_off_a: assert property (@(posedge clk_sys) disable iff (rst)
                !en[gi] |=> !lg[gi] && (bst[gi] != mcp_pkg::MCP_BK_HIGH))
                else $error("disabled buck still driving");
        end
    endgenerate

    assign high_gate_3v3 = hg[0];
    assign low_gate_3v3 = lg[0];
    assign high_gate_5v = hg[1];
    assign low_gate_5v = lg[1];

    // ****************************************
    // Buck-boost: both switches move together
    // ****************************************
    logic bb_on, next_bb_on;
    logic [9:0] bb_cnt, next_bb_cnt;

    always_comb begin
        next_bb_on = bb_on;
        next_bb_cnt = bb_on ? bb_cnt + 10'h1 : 10'h0;
        if (!en[2]) begin
            next_bb_on = 1'b0;
        end else if (bb_on) begin
            if (s_ilim[2] || bb_cnt == 10'(`MCP_MAX_DUTY_CYC - 1)
                || (pskip[2] ? s_peak[2] : s_ontime[2])) next_bb_on = 1'b0;
        end else if (tick && s_below[2] && !s_ilim[2]) begin
            next_bb_on = 1'b1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            bb_on <= 1'b0;
            bb_cnt <= 10'h0;
        end else begin
            bb_on <= next_bb_on;
            bb_cnt <= next_bb_cnt;
        end
    end

    assign high_gate_boost = bb_on && !s_ilim[2];
    assign low_gate_boost = bb_on && !s_ilim[2];

    boost_phase_a: assert property (@(posedge clk_sys) disable iff (rst)
        high_gate_boost == low_gate_boost) else $error("boost gates out of phase");
    boost_ilim_a: assert property (@(posedge clk_sys) disable iff (rst)
        s_ilim[2] |-> !high_gate_boost ##1 !bb_on) else $error("boost on at limit");
    osc_idle_a: assert property (@(posedge clk_sys) disable iff (rst)
        (en == 3'h0) |=> !osc_run) else $error("oscillator runs while idle");
    tie_follow_a: assert property (@(posedge clk_sys) disable iff (rst)
        ##1 ldo_tie_close == $past(s_out5)) else $error("tie path wrong");
    ref_order_a: assert property (@(posedge clk_sys) disable iff (rst)
        $rose(ref_en) |-> $past(s_ldo)) else $error("reference before regulator");
endmodule
`default_nettype wire

// file: mcp_power_stage_model.sv
`timescale 1ns/10ps
`default_nettype none
module mcp_power_stage_model #(
    parameter int ONTIME = 200,
    parameter int PEAK = 100,
    parameter int LIMIT = 600
) (
    // Clock
    input wire logic clk_sys,
    // Gate drives from the controller
    input wire logic high_gate,
    input wire logic low_gate,
    // Scenario knobs
    input wire logic heavy_load,
    input wire logic force_ilim,
    // Comparator indications
    output logic ontime_done,
    output logic peak_trip,
    output logic ilim_trip,
    output logic zero_cur,
    output logic below_reg
);
    int current = 0;
    // Current in arbitrary steps; it decays whether the low switch or the diodes carry it
    always @(posedge clk_sys) begin
        if (high_gate) begin
            current <= current + 1;
        end else if (current > 0) begin
            current <= current - 1;
        end
    end
    assign ontime_done = current >= ONTIME;
    assign peak_trip = current >= PEAK;
    // A shorted load is mimicked by the knob, the sense resistor never gets there alone
    assign ilim_trip = force_ilim || current >= LIMIT;
    // The zero-current comparator only reports while the low switch conducts
    assign zero_cur = current == 0 && low_gate;
    assign below_reg = heavy_load;
endmodule
`default_nettype wire

// file: testbench.sv
`timescale 1ns/10ps
`default_nettype none
`include "mcp_defs.svh"
module testbench;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic ldo_ok = 1'b0, ref_ok = 1'b0, out5_above_4v5 = 1'b0;
    logic cmd_valid = 1'b0, cmd_abort = 1'b0;
    logic [7:0] cmd_byte = 8'h00;
    logic [2:0] heavy = 3'h7, force_il = 3'h0;
    wire logic ldo_en, ref_en, osc_run, ldo_tie_close;
    wire logic [7:0] ss_level_3v3, ss_level_5v, ss_level_boost;
    wire logic ps3, ps5, psb, hg3, lg3, hg5, lg5, hgb, lgb;
    wire logic ot3, pk3, il3, zc3, br3, ot5, pk5, il5, zc5, br5, otb, pkb, ilb, brb;
    wire logic [10:0] obs;
    int mismatches = 0, samples_checked = 0, gap3 = 1000;
    logic [1:0] prev3 = 2'b00;
    logic cut3 = 1'b0;
    localparam int I_REF = 0, I_OSC = 1, I_TIE = 2, I_H3 = 3, I_HB = 6;
    localparam int I_F3 = 7, I_F5 = 8, I_FB = 9, I_SK = 10;
    assign obs = {ps3, ss_level_boost == 8'hff, ss_level_5v == 8'hff, ss_level_3v3 == 8'hff,
        hgb, hg5, lg3, hg3, ldo_tie_close, osc_run, ref_en};

    mcp_sequencer #(.SOFT_START_CYCLES(2560)) mcp_sequencer_inst (
        .clk_sys(clk_sys), .rst(rst), .ldo_ok(ldo_ok), .ref_ok(ref_ok),
        .out5_above_4v5(out5_above_4v5), .ontime_done_3v3(ot3), .peak_trip_3v3(pk3),
        .ilim_trip_3v3(il3), .zero_cur_3v3(zc3), .below_reg_3v3(br3),
        .ontime_done_5v(ot5), .peak_trip_5v(pk5), .ilim_trip_5v(il5), .zero_cur_5v(zc5),
        .below_reg_5v(br5), .ontime_done_boost(otb), .peak_trip_boost(pkb),
        .ilim_trip_boost(ilb), .below_reg_boost(brb), .cmd_valid(cmd_valid),
        .cmd_byte(cmd_byte), .cmd_abort(cmd_abort), .ldo_en(ldo_en), .ref_en(ref_en),
        .osc_run(osc_run), .ldo_tie_close(ldo_tie_close), .ss_level_3v3(ss_level_3v3),
        .ss_level_5v(ss_level_5v), .ss_level_boost(ss_level_boost),
        .pulse_skip_state_3v3(ps3), .pulse_skip_state_5v(ps5), .pulse_skip_state_boost(psb),
        .high_gate_3v3(hg3), .low_gate_3v3(lg3), .high_gate_5v(hg5), .low_gate_5v(lg5),
        .high_gate_boost(hgb), .low_gate_boost(lgb));
    mcp_power_stage_model mcp_power_stage_model_inst_3v3 (.clk_sys(clk_sys), .high_gate(hg3),
        .low_gate(lg3), .heavy_load(heavy[2]), .force_ilim(force_il[2]), .ontime_done(ot3),
        .peak_trip(pk3), .ilim_trip(il3), .zero_cur(zc3), .below_reg(br3));
    mcp_power_stage_model mcp_power_stage_model_inst_5v (.clk_sys(clk_sys), .high_gate(hg5),
        .low_gate(lg5), .heavy_load(heavy[1]), .force_ilim(force_il[1]), .ontime_done(ot5),
        .peak_trip(pk5), .ilim_trip(il5), .zero_cur(zc5), .below_reg(br5));
    mcp_power_stage_model mcp_power_stage_model_inst_boost (.clk_sys(clk_sys),
        .high_gate(hgb), .low_gate(lgb), .heavy_load(heavy[0]), .force_ilim(force_il[0]),
        .ontime_done(otb), .peak_trip(pkb), .ilim_trip(ilb), .zero_cur(), .below_reg(brb));

    initial begin
        forever #2.5 clk_sys = ~clk_sys;
    end

    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic give_verdict();
        $display("mismatches=%0d samples_checked=%0d", mismatches, samples_checked);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic step(input int n = 1);
        repeat (n) begin
            @(posedge clk_sys);
            #1;
        end
    endtask
    task automatic check(input logic got, input logic exp, input string msg);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: %s", $time, msg);
        end
    endtask
    // Bounded wait on one observed bit; running out ends the run
    task automatic wait_bit(input int idx, input logic val, input int bound, output int used);
        used = 0;
        while (obs[idx] !== val) begin
            if (used >= bound) begin
                mismatches++;
                $display("unexpected at %0t: wait on bit %0d timed out", $time, idx);
                give_verdict();
            end
            step();
            used++;
        end
        samples_checked++;
    endtask
    task automatic send(input logic [7:0] b, input logic ab);
        cmd_valid = 1'b1;
        cmd_byte = b;
        cmd_abort = ab;
        step();
        cmd_valid = 1'b0;
        cmd_abort = 1'b0;
    endtask
    task automatic watch(input int n, output logic [2:0] act);
        act = 3'h0;
        repeat (n) begin
            step();
            act = act | {hg3 | lg3, hg5 | lg5, hgb | lgb};
        end
    endtask

    // Gate overlap, in-phase boost drive and 3.3 V dead time seen on every cycle
    always @(negedge clk_sys) begin
        if (!rst) begin
            check(hg3 && lg3 || hg5 && lg5, 1'b0, "buck gates overlap");
            check(hgb, lgb, "boost gates out of phase");
            if (hg3 && !prev3[1]) check(gap3 >= `MCP_DEAD_CYC, 1'b1, "short gap");
            // A limit cut masks the high gate one cycle before the dead time starts
            if (lg3 && !prev3[0]) check(gap3 == `MCP_DEAD_CYC + int'(cut3), 1'b1, "bad gap");
        end
        if (prev3[1] && !hg3) cut3 = force_il[2];
        gap3 = (hg3 || lg3) ? 0 : gap3 + 1;
        prev3 = {hg3, lg3};
    end

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_reset();
        check(ldo_en, 1'b1, "regulator not first");
        check(ref_en | osc_run | hg3 | lg3 | hgb, 1'b0, "outputs active after reset");
        send(8'he0, 1'b0);
        step(5);
        check(osc_run, 1'b0, "command taken before regulator");
    endtask
    task automatic t_default();
        int u;
        ldo_ok = 1'b1;
        wait_bit(I_REF, 1'b1, 10, u);
        step(20);
        check(osc_run, 1'b0, "oscillator before reference");
        ref_ok = 1'b1;
        wait_bit(I_OSC, 1'b1, 10, u);
        wait_bit(I_F3, 1'b1, 3000, u);
        check(ss_level_5v === 8'h00 && ss_level_boost === 8'h00, 1'b1, "order 3v3");
        wait_bit(I_F5, 1'b1, 3000, u);
        check(ss_level_boost === 8'h00, 1'b1, "boost before 5v");
        wait_bit(I_FB, 1'b1, 3000, u);
    endtask
    task automatic t_tie();
        int u;
        out5_above_4v5 = 1'b1;
        wait_bit(I_TIE, 1'b1, 4, u);
        out5_above_4v5 = 1'b0;
        wait_bit(I_TIE, 1'b0, 4, u);
    endtask
    task automatic t_ilim(input int gi, input int fb);
        int u;
        wait_bit(gi, 1'b1, 1100, u);
        force_il[fb] = 1'b1;
        wait_bit(gi, 1'b0, 3, u);
        step(4);
        force_il[fb] = 1'b0;
        wait_bit(gi, 1'b1, 1100, u);
    endtask
    task automatic t_skip();
        int u;
        logic [2:0] act;
        heavy[2] = 1'b0;
        watch(1100, act);
        watch(1000, act);
        check(act[2], 1'b0, "pulse while above regulation");
        check(ps3, 1'b1, "pulse-skip flag clear");
        heavy[2] = 1'b1;
        wait_bit(I_H3, 1'b1, 1100, u);
        wait_bit(I_SK, 1'b0, 1100, u);
    endtask
    task automatic t_abort();
        send(8'h00, 1'b1);
        step(5);
        check(osc_run && obs[I_F3], 1'b1, "aborted command took effect");
    endtask
    task automatic t_cmds();
        logic [7:0] tbl [4] = '{8'h80, 8'h5f, 8'h20, 8'he0};
        logic [2:0] act;
        int u;
        foreach (tbl[i]) begin
            send(tbl[i], 1'b0);
            step(30);
            check(osc_run, 1'b1, "oscillator stopped");
            check(ss_level_3v3 != 8'h00, tbl[i][7], "3v3 enable");
            check(ss_level_5v != 8'h00, tbl[i][6], "5v enable");
            check(ss_level_boost != 8'h00, tbl[i][5], "boost enable");
            watch(1100, act);
            check(act === tbl[i][7:5], 1'b1, "gate activity differs");
        end
        send(8'h00, 1'b0);
        wait_bit(I_OSC, 1'b0, 4, u);
        watch(1100, act);
        check(act === 3'h0, 1'b1, "gates active while off");
        send(8'h40, 1'b0);
        wait_bit(I_OSC, 1'b1, 4, u);
        wait_bit(I_F5, 1'b1, 2700, u);
        check(u >= 2500, 1'b1, "soft-start too short");
    endtask

    initial begin
        repeat (10) @(posedge clk_sys);
        #1;
        rst = 1'b0;
        step();
        t_reset();
        t_default();
        t_tie();
        t_ilim(I_H3, 2);
        t_ilim(I_HB, 0);
        t_skip();
        t_abort();
        t_cmds();
        give_verdict();
    end
endmodule
`default_nettype wire
